// ---- core_regs_pkg.sv ----
package core_regs_pkg;

	// Widths and counts of the register storage
	localparam int XLEN = 32;
	localparam int NUM_GPR = 31;
	localparam int NUM_SAVED = 5;
	localparam int IDX_W = 4;
	localparam int PHYS_W = 5;

	// Architectural register indices
	localparam logic [3:0] IDX_SHARED_TOP = 4'h7;
	localparam logic [3:0] IDX_BANK_LO = 4'h8;
	localparam logic [3:0] IDX_FAST_LAST = 4'hc;
	localparam logic [3:0] IDX_STACK = 4'hd;
	localparam logic [3:0] IDX_LINK = 4'he;
	localparam logic [3:0] IDX_PC = 4'hf;

	// Physical slots of the banked copies
	localparam logic [4:0] PHYS_PC = 5'h0f;
	localparam logic [4:0] PHYS_FAST_BASE = 5'h10;
	localparam logic [4:0] PHYS_SVC_BASE = 5'h17;
	localparam logic [4:0] PHYS_ABT_BASE = 5'h19;
	localparam logic [4:0] PHYS_UND_BASE = 5'h1b;
	localparam logic [4:0] PHYS_IRQ_BASE = 5'h1d;

	// Mode codes as held in the status word
	localparam logic [4:0] CODE_USR = 5'h01;
	localparam logic [4:0] CODE_FAST = 5'h02;
	localparam logic [4:0] CODE_IRQ = 5'h03;
	localparam logic [4:0] CODE_SVC = 5'h04;
	localparam logic [4:0] CODE_ABT = 5'h05;
	localparam logic [4:0] CODE_SYS = 5'h06;
	localparam logic [4:0] CODE_UND = 5'h07;

	// Saved status slots
	localparam logic [2:0] SLOT_FAST = 3'h0;
	localparam logic [2:0] SLOT_IRQ = 3'h1;
	localparam logic [2:0] SLOT_SVC = 3'h2;
	localparam logic [2:0] SLOT_ABT = 3'h3;
	localparam logic [2:0] SLOT_UND = 3'h4;

	// Status word layout
	localparam int FLAGS_HI = 31;
	localparam int FLAGS_LO = 28;
	localparam int IRQ_DIS_BIT = 7;
	localparam int FAST_DIS_BIT = 6;
	localparam int COMPACT_BIT = 5;
	localparam int MODE_HI = 4;

	// Fetch steps per instruction width
	localparam logic [31:0] STEP_WIDE = 32'h0000_0004;
	localparam logic [31:0] STEP_COMPACT = 32'h0000_0002;
	localparam logic [31:0] RESET_PC = 32'h0000_0000;

	// Access sizes and kinds
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] KIND_LOAD = 2'h0;
	localparam logic [1:0] KIND_STORE = 2'h1;
	localparam logic [1:0] KIND_SWAP = 2'h2;

	typedef enum logic [6:0] {
		MODE_USR = 7'h01,
		MODE_FAST = 7'h02,
		MODE_IRQ = 7'h04,
		MODE_SVC = 7'h08,
		MODE_ABT = 7'h10,
		MODE_SYS = 7'h20,
		MODE_UND = 7'h40
	} mode_type;

	function automatic logic [4:0] mode_code(input mode_type m);
		case (m)
			MODE_FAST: mode_code = CODE_FAST;
			MODE_IRQ: mode_code = CODE_IRQ;
			MODE_SVC: mode_code = CODE_SVC;
			MODE_ABT: mode_code = CODE_ABT;
			MODE_SYS: mode_code = CODE_SYS;
			MODE_UND: mode_code = CODE_UND;
			default: mode_code = CODE_USR;
		endcase
	endfunction

	// Unknown codes fall back to user mode; status writes and exception entry check validity, restore does not
	function automatic mode_type code_mode(input logic [4:0] c);
		case (c)
			CODE_FAST: code_mode = MODE_FAST;
			CODE_IRQ: code_mode = MODE_IRQ;
			CODE_SVC: code_mode = MODE_SVC;
			CODE_ABT: code_mode = MODE_ABT;
			CODE_SYS: code_mode = MODE_SYS;
			CODE_UND: code_mode = MODE_UND;
			default: code_mode = MODE_USR;
		endcase
	endfunction

	function automatic logic code_valid(input logic [4:0] c);
		code_valid = (c >= CODE_USR) && (c <= CODE_UND);
	endfunction

endpackage

// ---- access_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface access_if;
	logic req;
	logic [31:0] addr;
	logic [1:0] size;
	logic [1:0] kind;
	logic [31:0] wdata;
	logic bus_req;
	logic [31:0] bus_addr;
	logic [3:0] bus_be;
	logic bus_we;
	logic [1:0] bus_rot;
	logic [31:0] bus_wdata;
	logic bus_abort;

	modport core (output req, addr, size, kind, wdata,
		input bus_req, bus_addr, bus_be, bus_we, bus_rot, bus_wdata, bus_abort);
	modport aligner (input req, addr, size, kind, wdata,
		output bus_req, bus_addr, bus_be, bus_we, bus_rot, bus_wdata, bus_abort);
endinterface
`default_nettype wire

// ---- access_aligner.sv ----
`timescale 1ns/100ps
`default_nettype none
module access_aligner (
	input wire logic core_clk,
	input wire logic sys_rst,
	access_if.aligner acc
);
	logic req_q, req_d, we_q, we_d, abort_q, abort_d;
	logic [31:0] addr_q, addr_d, wdata_q, wdata_d;
	logic [3:0] be_q, be_d;
	logic [1:0] rot_q, rot_d;
	logic misaligned;

	// Word needs low two bits clear, half-word the lowest bit
	assign misaligned = ((acc.size == core_regs_pkg::SIZE_WORD) && (acc.addr[1:0] != 2'h0)) ||
		((acc.size == core_regs_pkg::SIZE_HALF) && acc.addr[0]);

	// Lane decode and misalignment handling per instruction kind
	always_comb begin
		req_d = acc.req;
		we_d = acc.req && (acc.kind == core_regs_pkg::KIND_STORE);
		abort_d = 1'b0;
		rot_d = 2'h0;
		addr_d = acc.addr;
		wdata_d = acc.wdata;
		be_d = 4'hf;
		if (acc.size == core_regs_pkg::SIZE_BYTE) begin
			be_d = 4'h1 << acc.addr[1:0];
			wdata_d = {4{acc.wdata[7:0]}};
		end else if (acc.size == core_regs_pkg::SIZE_HALF) begin
			be_d = acc.addr[1] ? 4'hc : 4'h3;
			wdata_d = {2{acc.wdata[15:0]}};
		end
		if (acc.req && misaligned) begin
			if (acc.kind == core_regs_pkg::KIND_LOAD) begin
				addr_d = {acc.addr[31:2], 2'h0};
				rot_d = acc.addr[1:0];
			end else if (acc.kind == core_regs_pkg::KIND_STORE) begin
				addr_d = {acc.addr[31:2], 2'h0};
			end else begin
				req_d = 1'b0;
				we_d = 1'b0;
				abort_d = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			req_q <= 1'b0;
			we_q <= 1'b0;
			abort_q <= 1'b0;
			rot_q <= 2'h0;
			addr_q <= 32'h0;
			wdata_q <= 32'h0;
			be_q <= 4'h0;
		end else begin
			req_q <= req_d;
			we_q <= we_d;
			abort_q <= abort_d;
			rot_q <= rot_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			be_q <= be_d;
		end
	end

	assign acc.bus_req = req_q;
	assign acc.bus_we = we_q;
	assign acc.bus_abort = abort_q;
	assign acc.bus_rot = rot_q;
	assign acc.bus_addr = addr_q;
	assign acc.bus_wdata = wdata_q;
	assign acc.bus_be = be_q;

	AST_WORD_ADDR_ALIGNED: assert property (@(posedge core_clk) disable iff (sys_rst)
		acc.req && acc.size == core_regs_pkg::SIZE_WORD && acc.kind != core_regs_pkg::KIND_SWAP
		|=> acc.bus_req && acc.bus_addr[1:0] == 2'h0)
		else $error("word access left misaligned");
	AST_MISALIGNED_SWAP_ABORTS: assert property (@(posedge core_clk) disable iff (sys_rst)
		acc.req && misaligned && acc.kind == core_regs_pkg::KIND_SWAP |=> acc.bus_abort && !acc.bus_req)
		else $error("misaligned swap not aborted");
	AST_LOAD_ROTATES: assert property (@(posedge core_clk) disable iff (sys_rst)
		acc.req && misaligned && acc.kind == core_regs_pkg::KIND_LOAD
		|=> acc.bus_rot == $past(acc.addr[1:0]) && !acc.bus_abort)
		else $error("misaligned load rotate wrong");
endmodule
`default_nettype wire

// ---- banked_core_register_file.sv ----
// Notes on behaviour
// - Instructions move through fetch, decode and execute stages in that order.
// - The wide state handles 32-bit instructions and the compact state 16-bit ones.
// - Data transfers come in byte, half-word and word sizes.
// - Words align to four-byte and half-words to two-byte addresses.
// - A misaligned access is handled according to the kind of instruction doing it.
// - Seven modes exist: user, fast interrupt, interrupt, supervisor, abort, system and undefined.
// - The mode changes on a software status write or when an exception is taken.
// - Every mode but user is privileged.
// - Storage holds 31 general registers of 32 bits and 6 status registers.
// - Only 16 general registers are addressable at once, chosen by the mode.
// - Index 15 is the program counter and is readable as an operand.
// - A subroutine call puts its return address in index 14.
// - Indices 0 to 7 are shared by all modes, 8 to 14 depend on the mode.
// - Each exception mode has private indices 13 and 14, and 14 takes the return address on entry.
// - Fast interrupt mode also has private indices 8 to 12.
// - Each exception mode has a saved status register loaded with the old status on entry.
`timescale 1ns/100ps
`default_nettype none
module banked_core_register_file #(
	parameter logic [31:0] RESET_ADDR = core_regs_pkg::RESET_PC
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	output logic imem_req,
	output logic [31:0] imem_addr,
	input wire logic imem_ack,
	input wire logic [31:0] imem_rdata,
	output logic exe_valid,
	output logic [31:0] exe_instr,
	output logic [31:0] exe_pc,
	input wire logic [3:0] rd_a_idx,
	output logic [31:0] rd_a_data,
	input wire logic [3:0] rd_b_idx,
	output logic [31:0] rd_b_data,
	input wire logic wr_en,
	input wire logic [3:0] wr_idx,
	input wire logic [31:0] wr_data,
	input wire logic call_en,
	input wire logic [31:0] call_ret_addr,
	input wire logic status_wr_en,
	input wire logic [31:0] status_wr_data,
	input wire logic restore_en,
	input wire logic exc_req,
	input wire logic [4:0] exc_code,
	input wire logic [31:0] exc_vector,
	input wire logic [31:0] exc_ret_addr,
	output logic [31:0] status_word,
	output logic [31:0] saved_word,
	output logic privileged,
	input wire logic ls_req,
	input wire logic [31:0] ls_addr,
	input wire logic [1:0] ls_size,
	input wire logic [1:0] ls_kind,
	input wire logic [31:0] ls_wdata,
	output logic dmem_req,
	output logic [31:0] dmem_addr,
	output logic [3:0] dmem_be,
	output logic dmem_we,
	output logic [1:0] dmem_rot,
	output logic [31:0] dmem_wdata,
	output logic dmem_abort
);
	// Storage: 31 general registers and 6 status registers
	logic [31:0] regs_q [core_regs_pkg::NUM_GPR];
	logic [31:0] regs_d [core_regs_pkg::NUM_GPR];
	logic [31:0] saved_q [core_regs_pkg::NUM_SAVED];
	logic [31:0] saved_d [core_regs_pkg::NUM_SAVED];
	core_regs_pkg::mode_type mode_q, mode_d;
	logic [3:0] flags_q, flags_d;
	logic irq_dis_q, irq_dis_d, fast_dis_q, fast_dis_d, compact_q, compact_d;
	logic dec_valid_q, dec_valid_d, exe_valid_q, exe_valid_d;
	logic [31:0] dec_instr_q, dec_instr_d, dec_pc_q, dec_pc_d, exe_instr_q, exe_instr_d, exe_pc_q, exe_pc_d;
	logic flush, exc_take, pc_adv;
	logic [2:0] slot_cur, slot_exc;
	logic has_slot_cur;
	core_regs_pkg::mode_type exc_mode;
	logic [4:0] phys_a, phys_b, phys_w;

	// Mode and index to physical slot, no storage involved
	function automatic logic [4:0] phys_of(input core_regs_pkg::mode_type m, input logic [3:0] idx);
		logic [4:0] base;
		base = core_regs_pkg::PHYS_SVC_BASE;
		case (m)
			core_regs_pkg::MODE_ABT: base = core_regs_pkg::PHYS_ABT_BASE;
			core_regs_pkg::MODE_UND: base = core_regs_pkg::PHYS_UND_BASE;
			core_regs_pkg::MODE_IRQ: base = core_regs_pkg::PHYS_IRQ_BASE;
			default: base = core_regs_pkg::PHYS_SVC_BASE;
		endcase
		if (idx <= core_regs_pkg::IDX_SHARED_TOP || idx == core_regs_pkg::IDX_PC) begin
			phys_of = {1'b0, idx};
		end else if (m == core_regs_pkg::MODE_FAST) begin
			phys_of = core_regs_pkg::PHYS_FAST_BASE + {1'b0, idx - core_regs_pkg::IDX_BANK_LO};
		end else if (m == core_regs_pkg::MODE_USR || m == core_regs_pkg::MODE_SYS ||
			idx < core_regs_pkg::IDX_STACK) begin
			phys_of = {1'b0, idx};
		end else begin
			phys_of = base + {1'b0, idx - core_regs_pkg::IDX_STACK};
		end
	endfunction

	function automatic logic [2:0] slot_of(input core_regs_pkg::mode_type m);
		case (m)
			core_regs_pkg::MODE_FAST: slot_of = core_regs_pkg::SLOT_FAST;
			core_regs_pkg::MODE_IRQ: slot_of = core_regs_pkg::SLOT_IRQ;
			core_regs_pkg::MODE_ABT: slot_of = core_regs_pkg::SLOT_ABT;
			core_regs_pkg::MODE_UND: slot_of = core_regs_pkg::SLOT_UND;
			default: slot_of = core_regs_pkg::SLOT_SVC;
		endcase
	endfunction

	// Port selection straight from the current mode
	assign phys_a = phys_of(mode_q, rd_a_idx);
	assign phys_b = phys_of(mode_q, rd_b_idx);
	assign phys_w = phys_of(mode_q, wr_idx);
	assign rd_a_data = regs_q[phys_a];
	assign rd_b_data = regs_q[phys_b];
	assign privileged = (mode_q != core_regs_pkg::MODE_USR);
	assign status_word = {flags_q, 20'h0, irq_dis_q, fast_dis_q, compact_q, core_regs_pkg::mode_code(mode_q)};
	assign has_slot_cur = privileged && (mode_q != core_regs_pkg::MODE_SYS);
	assign slot_cur = slot_of(mode_q);
	assign saved_word = has_slot_cur ? saved_q[slot_cur] : 32'h0;
	assign exc_mode = core_regs_pkg::code_mode(exc_code);
	assign slot_exc = slot_of(exc_mode);
	assign exc_take = exc_req && core_regs_pkg::code_valid(exc_code) &&
		exc_mode != core_regs_pkg::MODE_USR && exc_mode != core_regs_pkg::MODE_SYS;
	assign flush = exc_take || (restore_en && has_slot_cur) ||
		(wr_en && wr_idx == core_regs_pkg::IDX_PC) ||
		(status_wr_en && privileged && status_wr_data[core_regs_pkg::COMPACT_BIT] != compact_q);
	assign pc_adv = imem_ack && !flush;
	assign imem_req = !sys_rst;
	assign imem_addr = regs_q[core_regs_pkg::PHYS_PC];

	// Next state of registers, status and pipeline; later steps take priority
	always_comb begin
		regs_d = regs_q;
		saved_d = saved_q;
		mode_d = mode_q;
		flags_d = flags_q;
		irq_dis_d = irq_dis_q;
		fast_dis_d = fast_dis_q;
		compact_d = compact_q;
		dec_valid_d = 1'b0;
		dec_instr_d = dec_instr_q;
		dec_pc_d = dec_pc_q;
		exe_valid_d = dec_valid_q && !flush;
		exe_instr_d = dec_instr_q;
		exe_pc_d = dec_pc_q;
		if (pc_adv) begin
			dec_valid_d = 1'b1;
			dec_pc_d = imem_addr;
			if (compact_q) begin
				dec_instr_d = {16'h0, imem_addr[1] ? imem_rdata[31:16] : imem_rdata[15:0]};
				regs_d[core_regs_pkg::PHYS_PC] = imem_addr + core_regs_pkg::STEP_COMPACT;
			end else begin
				dec_instr_d = imem_rdata;
				regs_d[core_regs_pkg::PHYS_PC] = imem_addr + core_regs_pkg::STEP_WIDE;
			end
		end
		if (wr_en) begin
			regs_d[phys_w] = wr_data;
		end
		if (call_en) begin
			regs_d[phys_of(mode_q, core_regs_pkg::IDX_LINK)] = call_ret_addr;
		end
		if (status_wr_en) begin
			flags_d = status_wr_data[core_regs_pkg::FLAGS_HI:core_regs_pkg::FLAGS_LO];
			if (privileged) begin
				irq_dis_d = status_wr_data[core_regs_pkg::IRQ_DIS_BIT];
				fast_dis_d = status_wr_data[core_regs_pkg::FAST_DIS_BIT];
				compact_d = status_wr_data[core_regs_pkg::COMPACT_BIT];
				if (core_regs_pkg::code_valid(status_wr_data[core_regs_pkg::MODE_HI:0])) begin
					mode_d = core_regs_pkg::code_mode(status_wr_data[core_regs_pkg::MODE_HI:0]);
				end
			end
		end
		if (restore_en && has_slot_cur) begin
			flags_d = saved_q[slot_cur][core_regs_pkg::FLAGS_HI:core_regs_pkg::FLAGS_LO];
			irq_dis_d = saved_q[slot_cur][core_regs_pkg::IRQ_DIS_BIT];
			fast_dis_d = saved_q[slot_cur][core_regs_pkg::FAST_DIS_BIT];
			compact_d = saved_q[slot_cur][core_regs_pkg::COMPACT_BIT];
			mode_d = core_regs_pkg::code_mode(saved_q[slot_cur][core_regs_pkg::MODE_HI:0]);
		end
		if (exc_take) begin
			saved_d[slot_exc] = status_word;
			mode_d = exc_mode;
			irq_dis_d = 1'b1;
			fast_dis_d = fast_dis_q || (exc_mode == core_regs_pkg::MODE_FAST);
			compact_d = 1'b0;
			regs_d[phys_of(exc_mode, core_regs_pkg::IDX_LINK)] = exc_ret_addr;
			regs_d[core_regs_pkg::PHYS_PC] = exc_vector;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < core_regs_pkg::NUM_GPR; i++) begin
				regs_q[i] <= 32'h0;
			end
			for (int i = 0; i < core_regs_pkg::NUM_SAVED; i++) begin
				saved_q[i] <= 32'h0;
			end
			regs_q[core_regs_pkg::PHYS_PC] <= RESET_ADDR;
			mode_q <= core_regs_pkg::MODE_SVC;
			flags_q <= 4'h0;
			irq_dis_q <= 1'b1;
			fast_dis_q <= 1'b1;
			compact_q <= 1'b0;
			dec_valid_q <= 1'b0;
			exe_valid_q <= 1'b0;
			dec_instr_q <= 32'h0;
			dec_pc_q <= 32'h0;
			exe_instr_q <= 32'h0;
			exe_pc_q <= 32'h0;
		end else begin
			regs_q <= regs_d;
			saved_q <= saved_d;
			mode_q <= mode_d;
			flags_q <= flags_d;
			irq_dis_q <= irq_dis_d;
			fast_dis_q <= fast_dis_d;
			compact_q <= compact_d;
			dec_valid_q <= dec_valid_d;
			exe_valid_q <= exe_valid_d;
			dec_instr_q <= dec_instr_d;
			dec_pc_q <= dec_pc_d;
			exe_instr_q <= exe_instr_d;
			exe_pc_q <= exe_pc_d;
		end
	end

	assign exe_valid = exe_valid_q;
	assign exe_instr = exe_instr_q;
	assign exe_pc = exe_pc_q;

	// Data access path through the alignment stage
	access_if acc ();
	assign acc.req = ls_req;
	assign acc.addr = ls_addr;
	assign acc.size = ls_size;
	assign acc.kind = ls_kind;
	assign acc.wdata = ls_wdata;
	access_aligner u_aligner (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.acc(acc.aligner)
	);
	assign dmem_req = acc.bus_req;
	assign dmem_addr = acc.bus_addr;
	assign dmem_be = acc.bus_be;
	assign dmem_we = acc.bus_we;
	assign dmem_rot = acc.bus_rot;
	assign dmem_wdata = acc.bus_wdata;
	assign dmem_abort = acc.bus_abort;

	sequence fetch_taken_s;
		pc_adv;
	endsequence
	sequence clean_s;
		!flush;
	endsequence

	AST_PIPE_ORDER: assert property (@(posedge core_clk) disable iff (sys_rst)
		fetch_taken_s ##1 clean_s |=> exe_valid && exe_pc == $past(dec_pc_q))
		else $error("fetched word did not reach execute in order");
	AST_COMPACT_WIDTH: assert property (@(posedge core_clk) disable iff (sys_rst)
		fetch_taken_s and compact_q |=> dec_instr_q[31:16] == 16'h0 &&
		regs_q[core_regs_pkg::PHYS_PC] == $past(imem_addr) + core_regs_pkg::STEP_COMPACT)
		else $error("compact fetch width wrong");
	AST_SHARED_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
		rd_a_idx <= core_regs_pkg::IDX_SHARED_TOP |-> phys_a == {1'b0, rd_a_idx})
		else $error("low index banked");
	AST_FAST_PRIVATE: assert property (@(posedge core_clk) disable iff (sys_rst)
		mode_q == core_regs_pkg::MODE_FAST && rd_a_idx >= core_regs_pkg::IDX_BANK_LO &&
		rd_a_idx <= core_regs_pkg::IDX_FAST_LAST |-> phys_a >= core_regs_pkg::PHYS_FAST_BASE)
		else $error("fast interrupt copy not selected");
	AST_PC_OPERAND: assert property (@(posedge core_clk) disable iff (sys_rst)
		rd_b_idx == core_regs_pkg::IDX_PC |-> rd_b_data == imem_addr)
		else $error("index 15 is not the program counter");
	AST_EXC_ENTRY: assert property (@(posedge core_clk) disable iff (sys_rst)
		exc_take |=> mode_q == $past(exc_mode) && privileged &&
		regs_q[phys_of(mode_q, core_regs_pkg::IDX_LINK)] == $past(exc_ret_addr))
		else $error("exception entry link or mode wrong");
	AST_SAVED_CAPTURE: assert property (@(posedge core_clk) disable iff (sys_rst)
		exc_take |=> saved_word == $past(status_word))
		else $error("saved status not captured");
	AST_USER_STAYS: assert property (@(posedge core_clk) disable iff (sys_rst)
		status_wr_en && !privileged && !exc_take |=> !privileged && irq_dis_q == $past(irq_dis_q))
		else $error("user mode changed privileged state");
	AST_CALL_LINK: assert property (@(posedge core_clk) disable iff (sys_rst)
		call_en && !exc_take && !restore_en && !status_wr_en
		|=> regs_q[phys_of(mode_q, core_regs_pkg::IDX_LINK)] == $past(call_ret_addr))
		else $error("call return address lost");
endmodule
`default_nettype wire

// ---- instr_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module instr_mem_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic imem_req,
	input wire logic [31:0] imem_addr,
	output logic imem_ack,
	output logic [31:0] imem_rdata
);
	logic gap_q;
	logic [31:0] word;
	// Slow memory leaves a gap every other cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			gap_q <= 1'b0;
		end else begin
			gap_q <= slow & ~gap_q;
		end
	end
	// Word pattern, inverted while not answering
	assign word = {imem_addr[31:2], 2'b00} ^ 32'h5a5a_0000;
	assign imem_ack = imem_req & ~gap_q;
	assign imem_rdata = imem_ack ? word : ~word;
endmodule
`default_nettype wire

// ---- banked_core_register_file_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module banked_core_register_file_test;
	logic core_clk, sys_rst, slow, imem_req, imem_ack, exe_valid, wr_en, call_en, status_wr_en;
	logic restore_en, exc_req, privileged, ls_req, dmem_req, dmem_we, dmem_abort;
	logic [31:0] imem_addr, imem_rdata, exe_instr, exe_pc, rd_a_data, rd_b_data, wr_data, call_ret_addr;
	logic [31:0] status_wr_data, exc_vector, exc_ret_addr, status_word, saved_word, ls_addr, ls_wdata;
	logic [31:0] dmem_addr, dmem_wdata;
	logic [3:0] rd_a_idx, rd_b_idx, wr_idx, dmem_be;
	logic [4:0] exc_code;
	logic [1:0] ls_size, ls_kind, dmem_rot;
	int mismatches, cmp_count;

	banked_core_register_file dut (.core_clk, .sys_rst, .imem_req, .imem_addr, .imem_ack, .imem_rdata,
		.exe_valid, .exe_instr, .exe_pc, .rd_a_idx, .rd_a_data, .rd_b_idx, .rd_b_data, .wr_en, .wr_idx,
		.wr_data, .call_en, .call_ret_addr, .status_wr_en, .status_wr_data, .restore_en, .exc_req,
		.exc_code, .exc_vector, .exc_ret_addr, .status_word, .saved_word, .privileged, .ls_req, .ls_addr,
		.ls_size, .ls_kind, .ls_wdata, .dmem_req, .dmem_addr, .dmem_be, .dmem_we, .dmem_rot, .dmem_wdata,
		.dmem_abort);
	instr_mem_model mem (.core_clk, .sys_rst, .slow, .imem_req, .imem_addr, .imem_ack, .imem_rdata);

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] word_at(input logic [31:0] a);
		return {a[31:2], 2'b00} ^ 32'h5a5a_0000;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic tick;
		@(negedge core_clk);
	endtask

	task automatic rd(input logic [3:0] i, input logic [31:0] e);
		rd_a_idx = i;
		rd_b_idx = i;
		#1;
		chk(rd_a_data, e, "read port a");
		chk(rd_b_data, e, "read port b");
		tick;
	endtask

	task automatic wr(input logic [3:0] i, input logic [31:0] d);
		wr_en = 1'b1;
		wr_idx = i;
		wr_data = d;
		tick;
		wr_en = 1'b0;
	endtask

	task automatic sw(input logic [31:0] d);
		status_wr_en = 1'b1;
		status_wr_data = d;
		tick;
		status_wr_en = 1'b0;
	endtask

	task automatic wait_exe;
		int n;
		n = 0;
		tick;
		while (exe_valid !== 1'b1 && n < 40) begin
			tick;
			n++;
		end
		chk(exe_valid, 1'b1, "execute stage valid");
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Reset state, then first fetches in order
	task automatic t_reset_fetch;
		chk(imem_req, 1'b0, "fetch during reset");
		sys_rst = 1'b0;
		chk(status_word, 32'h0000_00c4, "reset status");
		chk(privileged, 1'b1, "reset privileged");
		chk(dmem_req, 1'b0, "reset data request");
		rd(4'h3, 32'h0);
		wait_exe;
		chk(exe_pc, 32'h0, "first pc");
		chk(exe_instr, word_at(32'h0), "first word");
		wait_exe;
		chk(exe_pc, 32'h4, "second pc");
		$display("test reset_fetch done");
	endtask

	// Shared and banked indices across modes
	task automatic t_banks;
		wr(4'h3, 32'h1111_1111);
		rd(4'h3, 32'h1111_1111);
		wr(4'h8, 32'h8888_8888);
		rd(4'h8, 32'h8888_8888);
		wr(4'hd, 32'hdddd_0000);
		rd(4'hd, 32'hdddd_0000);
		sw(32'h0000_00c2);
		chk(status_word, 32'h0000_00c2, "fast mode entered");
		rd(4'h3, 32'h1111_1111);
		rd(4'h8, 32'h0);
		rd(4'hd, 32'h0);
		wr(4'h8, 32'hf8f8_f8f8);
		rd(4'h8, 32'hf8f8_f8f8);
		sw(32'h0000_00c6);
		rd(4'h8, 32'h8888_8888);
		rd(4'hd, 32'h0);
		$display("test banks done");
	endtask

	// Compact fetch with a slow memory, then program counter writes
	task automatic t_compact_pc;
		slow = 1'b1;
		sw(32'h0000_00e6);
		wr(4'hf, 32'h300);
		wait_exe;
		chk(exe_pc, 32'h300, "compact pc");
		chk(exe_instr, word_at(32'h300) & 32'h0000_ffff, "low half");
		wait_exe;
		chk(exe_pc, 32'h302, "compact step");
		chk(exe_instr, word_at(32'h300) >> 16, "high half");
		sw(32'h0000_00c6);
		slow = 1'b0;
		wr(4'hf, 32'h200);
		chk(imem_addr, 32'h200, "pc written");
		rd(4'hf, 32'h200);
		wait_exe;
		chk(exe_pc, 32'h200, "pc target");
		$display("test compact_pc done");
	endtask

	task automatic do_ls(input logic [31:0] a, input logic [1:0] s, input logic [1:0] k, input logic [31:0] wd,
		input logic ereq, input logic eab, input logic [3:0] ebe, input logic [1:0] erot, input logic crot,
		input logic [31:0] ewd);
		ls_req = 1'b1;
		ls_addr = a;
		ls_size = s;
		ls_kind = k;
		ls_wdata = wd;
		tick;
		chk(dmem_req, ereq, "data request");
		chk(dmem_abort, eab, "data abort");
		if (ereq) begin
			chk(dmem_be, ebe, "byte lanes");
			chk(dmem_addr[31:2], a[31:2], "data address");
			chk(dmem_we, {31'h0, k == core_regs_pkg::KIND_STORE}, "write strobe");
		end
		if (crot) begin
			chk(dmem_addr, a & 32'hffff_fffc, "aligned down");
			chk(dmem_rot, erot, "rotation");
		end
		if (ereq && k == core_regs_pkg::KIND_STORE) begin
			chk(dmem_wdata, ewd, "write data");
		end
	endtask

	// Back-to-back data accesses of every size and kind
	task automatic t_data;
		do_ls(32'h13, core_regs_pkg::SIZE_BYTE, core_regs_pkg::KIND_STORE, 32'hab,
			1'b1, 1'b0, 4'h8, 2'h0, 1'b0, 32'habab_abab);
		do_ls(32'h12, core_regs_pkg::SIZE_HALF, core_regs_pkg::KIND_STORE, 32'h1234,
			1'b1, 1'b0, 4'hc, 2'h0, 1'b0, 32'h1234_1234);
		do_ls(32'h22, core_regs_pkg::SIZE_HALF, core_regs_pkg::KIND_LOAD, 32'h0,
			1'b1, 1'b0, 4'hc, 2'h0, 1'b0, 32'h0);
		do_ls(32'h1, core_regs_pkg::SIZE_BYTE, core_regs_pkg::KIND_LOAD, 32'h0,
			1'b1, 1'b0, 4'h2, 2'h0, 1'b0, 32'h0);
		do_ls(32'h6, core_regs_pkg::SIZE_WORD, core_regs_pkg::KIND_LOAD, 32'h0,
			1'b1, 1'b0, 4'hf, 2'h2, 1'b1, 32'h0);
		do_ls(32'h7, core_regs_pkg::SIZE_WORD, core_regs_pkg::KIND_STORE, 32'h5678,
			1'b1, 1'b0, 4'hf, 2'h0, 1'b1, 32'h5678);
		do_ls(32'h5, core_regs_pkg::SIZE_WORD, core_regs_pkg::KIND_SWAP, 32'h0,
			1'b0, 1'b1, 4'h0, 2'h0, 1'b0, 32'h0);
		do_ls(32'h2, core_regs_pkg::SIZE_HALF, core_regs_pkg::KIND_SWAP, 32'h0,
			1'b1, 1'b0, 4'hc, 2'h0, 1'b0, 32'h0);
		ls_req = 1'b0;
		$display("test data done");
	endtask

	// User mode, every exception kind, restore and call
	task automatic t_exc;
		logic [4:0] codes[5];
		codes = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h07};
		sw(32'h0000_00c1);
		chk(privileged, 1'b0, "user unprivileged");
		tick;
		sw(32'ha000_00c4);
		chk(status_word, 32'ha000_00c1, "user flags only");
		foreach (codes[i]) begin
			exc_req = 1'b1;
			exc_code = codes[i];
			exc_vector = 32'h400 + 32'(i) * 32'h10;
			exc_ret_addr = 32'h1000 + 32'(i);
			tick;
			exc_req = 1'b0;
			chk(status_word, {4'ha, 20'h0, 3'b110, codes[i]}, "exception status");
			chk(saved_word, 32'ha000_00c1, "saved status");
			chk(privileged, 1'b1, "exception privileged");
			chk(imem_addr, 32'h400 + 32'(i) * 32'h10, "vector fetch");
			rd(4'he, 32'h1000 + 32'(i));
			rd(4'hd, (codes[i] == 5'h04) ? 32'hdddd_0000 : 32'h0);
			restore_en = 1'b1;
			tick;
			restore_en = 1'b0;
			chk(status_word, 32'ha000_00c1, "restored status");
		end
		exc_req = 1'b1;
		exc_code = 5'h06;
		tick;
		exc_req = 1'b0;
		chk(status_word, 32'ha000_00c1, "invalid code ignored");
		call_en = 1'b1;
		call_ret_addr = 32'h5550;
		tick;
		call_en = 1'b0;
		rd(4'he, 32'h5550);
		$display("test exceptions done");
	endtask

	// Watchdog
	initial begin
		#(25 * 5000);
		mismatches++;
		give_verdict;
	end

	// Main sequence
	initial begin
		{sys_rst, slow, wr_en, call_en, status_wr_en, restore_en, exc_req, ls_req} = 8'h80;
		{rd_a_idx, rd_b_idx, wr_idx, exc_code, ls_size, ls_kind} = 21'h0;
		{wr_data, call_ret_addr, status_wr_data, exc_vector, exc_ret_addr, ls_addr, ls_wdata} = '0;
		mismatches = 0;
		cmp_count = 0;
		repeat (20) tick;
		t_reset_fetch;
		t_banks;
		t_compact_pc;
		t_data;
		t_exc;
		give_verdict;
	end
endmodule
`default_nettype wire
